// *** design/dmabm_ctrl.sv ***
// DMA bus-mode and request-mode controller with APB registers
`timescale 1ns/1ns
module dmabm_ctrl
  import dmabm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer requests
  input wire logic [NCH-1:0] ext_xfer_request,
  input wire logic [NCH-1:0] periph_request,
  // System bus arbiter
  output logic bus_req,
  input wire logic bus_grant,
  // Bus cycles
  output logic cyc_valid,
  output logic cyc_write,
  output logic cyc_chan,
  output logic [1:0] cyc_size,
  output logic [31:0] cyc_wdata,
  input wire logic [31:0] cyc_rdata,
  input wire logic cyc_done,
  // Acknowledge strobes
  output logic [NCH-1:0] xfer_ack_strobe
);
  typedef struct packed {
    dmabm_state_t st;
    logic [NCH-1:0][CTL_W-1:0] ctrl;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0] done;
    logic [NCH-1:0] err;
    logic ch;
    logic [1:0] beat;
    logic [1:0] gap;
    logic [31:0] hold;
    logic [31:0] prdata;
    logic bus_req;
    logic cyc_valid;
    logic cyc_write;
    logic [1:0] size;
    logic [NCH-1:0] ack;
  } dmabm_regs_t;
  dmabm_regs_t s_q;
  dmabm_regs_t s_d;

  logic [NCH-1:0] pend;
  logic [NCH-1:0] consume;
  logic [CTL_W-1:0] cur;
  logic [1:0] cur_sz;
  logic [1:0] cur_src;
  logic [1:0] last_beat;
  logic burst_eff;
  logic lvl_ext;
  logic lvl_drop;
  logic unit_last;

  // ***********************************************************
  // Legality of a channel setup
  // ***********************************************************
  function automatic logic cfg_legal(input logic [CTL_W-1:0] c, input logic [CNT_W-1:0] n);
    logic [1:0] src;
    logic [1:0] sz;
    logic anyp;
    logic pp;
    src = c[CTL_SRC +: 2];
    sz = {c[CTL_SZ_HI], c[CTL_SZ_LO]};
    anyp = c[CTL_SRCP] | c[CTL_DSTP];
    pp = c[CTL_SRCP] & c[CTL_DSTP];
    cfg_legal = (n != CNT_RESET) && (src == SRC_AUTO || src == SRC_EXT || src == SRC_PERIPH)
      && !(c[CTL_SINGLE] && (src != SRC_EXT || anyp))
      && !((anyp || src == SRC_PERIPH) && sz == SZ_16)
      && !(pp && (src != SRC_AUTO || !c[CTL_BURST]));
  endfunction : cfg_legal

  // ***********************************************************
  // Request detectors
  // ***********************************************************
  for (genvar i = 0; i < NCH; i++)
  begin : g_det
    dmabm_req_detect u_det (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(s_q.ctrl[i][CTL_EN]),
      .source(s_q.ctrl[i][CTL_SRC +: 2]),
      .edge_mode(s_q.ctrl[i][CTL_EDGE]),
      .ext_req(ext_xfer_request[i]),
      .periph_req(periph_request[i]),
      .consume(consume[i]),
      .pending(pend[i])
    );
  end

  // ***********************************************************
  // Active channel decode
  // ***********************************************************
  always_comb
  begin
    cur = s_q.ctrl[s_q.ch];
    cur_sz = {cur[CTL_SZ_HI], cur[CTL_SZ_LO]};
    cur_src = cur[CTL_SRC +: 2];
    last_beat = (cur_sz == SZ_16) ? BEAT_LAST_16 : 2'h0;
    burst_eff = cur[CTL_BURST] && cur_src != SRC_PERIPH;
    lvl_ext = cur_src == SRC_EXT && !cur[CTL_EDGE];
    lvl_drop = lvl_ext && !ext_xfer_request[s_q.ch];
    unit_last = s_q.beat == last_beat;
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb
  begin
    s_d = s_q;
    consume = '0;
    // APB access; later hardware updates win over these
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_CTRL0: s_d.prdata = {21'h000000, s_q.ctrl[0]};
        ADDR_CNT0: s_d.prdata = {16'h0000, s_q.cnt[0]};
        ADDR_CTRL1: s_d.prdata = {21'h000000, s_q.ctrl[1]};
        ADDR_CNT1: s_d.prdata = {16'h0000, s_q.cnt[1]};
        ADDR_STAT: s_d.prdata = {26'h0000000, s_q.ch, s_q.st != ST_IDLE, s_q.err, s_q.done};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite)
    begin
      unique case (paddr)
        ADDR_CTRL0: s_d.ctrl[0] = pwdata[CTL_W-1:0];
        ADDR_CNT0: s_d.cnt[0] = pwdata[CNT_W-1:0];
        ADDR_CTRL1: s_d.ctrl[1] = pwdata[CTL_W-1:0];
        ADDR_CNT1: s_d.cnt[1] = pwdata[CNT_W-1:0];
        ADDR_STAT:
        begin
          s_d.done = s_q.done & ~pwdata[STA_DONE +: NCH];
          s_d.err = s_q.err & ~pwdata[STA_ERR +: NCH];
        end
        default: ;
      endcase
    end
    unique case (s_q.st)
      ST_IDLE:
      begin
        // Channel 0 has fixed priority over channel 1
        for (int i = NCH - 1; i >= 0; i--)
        begin
          if (s_q.ctrl[i][CTL_EN] && !cfg_legal(s_q.ctrl[i], s_q.cnt[i]))
          begin
            s_d.err[i] = 1'b1;
            s_d.ctrl[i][CTL_EN] = 1'b0;
          end
          else if (pend[i])
          begin
            s_d.ch = i[0];
            s_d.st = ST_ARB;
          end
        end
        s_d.beat = 2'h0;
      end
      ST_ARB:
      begin
        if (bus_grant)
        begin
          consume[s_q.ch] = 1'b1;
          s_d.st = cur[CTL_SINGLE] ? ST_SGL : ST_RD;
        end
      end
      ST_RD:
      begin
        if (cyc_done)
        begin
          s_d.hold = cyc_rdata;
          s_d.st = ST_WR;
        end
      end
      ST_WR, ST_SGL:
      begin
        if (cyc_done)
        begin
          if (!unit_last)
          begin
            s_d.beat = s_q.beat + 2'h1;
            s_d.st = (s_q.st == ST_WR) ? ST_RD : ST_SGL;
          end
          else
          begin
            s_d.beat = 2'h0;
            s_d.cnt[s_q.ch] = s_q.cnt[s_q.ch] - 16'h0001;
            s_d.st = ST_REL;
            if (s_q.cnt[s_q.ch] == 16'h0001)
            begin
              s_d.done[s_q.ch] = 1'b1;
              s_d.ctrl[s_q.ch][CTL_EN] = 1'b0;
            end
            else if (burst_eff && !lvl_drop)
            begin
              consume[s_q.ch] = 1'b1;
              s_d.st = cur[CTL_SINGLE] ? ST_SGL : ST_RD;
            end
          end
        end
      end
      ST_REL:
      begin
        if (s_q.gap == 2'h1)
        begin
          s_d.st = ST_IDLE;
        end
        else
        begin
          s_d.gap = s_q.gap - 2'h1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Longer gap lets the CPU in twice when the strobe trails the unit
    if (s_d.st == ST_REL && s_q.st != ST_REL)
    begin
      s_d.gap = (cur[CTL_ACKW] || cur[CTL_SINGLE]) ? GAP_LONG : GAP_SHORT;
    end
    s_d.bus_req = s_d.st inside {ST_ARB, ST_RD, ST_WR, ST_SGL};
    s_d.cyc_valid = s_d.st inside {ST_RD, ST_WR, ST_SGL};
    s_d.cyc_write = s_d.st == ST_WR;
    s_d.size = (s_d.ch == s_q.ch && cur_sz == SZ_16) ? SZ_LONG :
      {s_d.ctrl[s_d.ch][CTL_SZ_HI], s_d.ctrl[s_d.ch][CTL_SZ_LO]};
    s_d.ack = '0;
    if (s_d.st == ST_SGL || (s_d.st == ST_RD && !s_d.ctrl[s_d.ch][CTL_ACKW]) ||
        (s_d.st == ST_WR && s_d.ctrl[s_d.ch][CTL_ACKW]))
    begin
      s_d.ack[s_d.ch] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr inside
    {ADDR_CTRL0, ADDR_CNT0, ADDR_CTRL1, ADDR_CNT1, ADDR_STAT});
  assign prdata = s_q.prdata;
  assign bus_req = s_q.bus_req;
  assign cyc_valid = s_q.cyc_valid;
  assign cyc_write = s_q.cyc_write;
  assign cyc_chan = s_q.ch;
  assign cyc_size = s_q.size;
  assign cyc_wdata = s_q.hold;
  assign xfer_ack_strobe = s_q.ack;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence rd_done_s;
    s_q.st == ST_RD && cyc_done;
  endsequence
  sequence wr_follows_s;
    s_q.st == ST_WR && cyc_write && cyc_valid;
  endsequence

  ack_place_a: assert property ((cyc_valid && xfer_ack_strobe != '0
    && !s_q.ctrl[cyc_chan][CTL_SINGLE]) |-> cyc_write == s_q.ctrl[cyc_chan][CTL_ACKW])
    else $error("strobe in wrong dual cycle");
  grant_first_a: assert property ($rose(cyc_valid) |-> $past(bus_grant) && bus_req)
    else $error("cycle started without grant");
  dual_hold_a: assert property (rd_done_s |=>
    wr_follows_s and cyc_wdata == $past(cyc_rdata))
    else $error("read datum not written next");
  steal_rel_a: assert property ((s_q.st inside {ST_WR, ST_SGL} && cyc_done && unit_last
    && !burst_eff) |=> !bus_req ##1 !bus_req)
    else $error("cycle-steal kept the bus");
  hold_16_a: assert property ((s_q.st == ST_WR && cyc_done && !unit_last)
    |=> s_q.st == ST_RD && bus_req)
    else $error("sixteen-byte unit released bus");
  burst_keep_a: assert property ((s_q.st inside {ST_WR, ST_SGL} && cyc_done && unit_last
    && burst_eff && !lvl_drop && s_q.cnt[s_q.ch] > 16'h0001) |=> bus_req && cyc_valid)
    else $error("burst dropped the bus");
  level_drop_a: assert property ((s_q.st inside {ST_WR, ST_SGL} && cyc_done && unit_last
    && lvl_drop) |=> !bus_req)
    else $error("bus held after request drop");
  periph_steal_a: assert property ((s_q.st == ST_WR && cyc_done && unit_last
    && cur_src == SRC_PERIPH) |=> !bus_req)
    else $error("peripheral source kept the bus");
  single_ext_a: assert property ((s_q.st == ST_SGL) |-> cur_src == SRC_EXT && !cyc_write)
    else $error("single address without external request");
  gap_len_a: assert property ((s_q.st != ST_REL ##1 s_q.st == ST_REL && (cur[CTL_ACKW] || cur[CTL_SINGLE]))
    |-> s_q.st == ST_REL [*2])
    else $error("release gap too short");
endmodule : dmabm_ctrl

// *** design/dmabm_pkg.sv ***
// Shared constants for the DMA bus-mode and request-mode controller
package dmabm_pkg;
  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int NCH = 2;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int CTL_W = 11;
  // ***********************************************************
  // Register byte offsets
  // ***********************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CNT1 = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;
  // ***********************************************************
  // Channel control fields
  // ***********************************************************
  localparam int CTL_EN = 0;
  localparam int CTL_ACKW = 1;
  localparam int CTL_BURST = 2;
  localparam int CTL_SZ_LO = 3;
  localparam int CTL_SZ_HI = 4;
  localparam int CTL_EDGE = 5;
  localparam int CTL_SRC = 6;
  localparam int CTL_SINGLE = 8;
  localparam int CTL_SRCP = 9;
  localparam int CTL_DSTP = 10;
  localparam logic [CTL_W-1:0] CTL_RESET = 11'h000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  // ***********************************************************
  // Status fields
  // ***********************************************************
  localparam int STA_DONE = 0;
  localparam int STA_ERR = 2;
  localparam int STA_BUSY = 4;
  localparam int STA_CH = 5;
  // ***********************************************************
  // Encodings and timing
  // ***********************************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_16 = 2'h3;
  localparam logic [1:0] SRC_AUTO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_PERIPH = 2'h2;
  localparam logic [1:0] BEAT_LAST_16 = 2'h3;
  localparam logic [1:0] GAP_SHORT = 2'h1;
  localparam logic [1:0] GAP_LONG = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_RD, ST_WR, ST_SGL, ST_REL} dmabm_state_t;
endpackage : dmabm_pkg

// *** design/dmabm_req_detect.sv ***
// Per-channel transfer request detector
`timescale 1ns/1ns
module dmabm_req_detect
  import dmabm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Channel setup
  input wire logic enable,
  input wire logic [1:0] source,
  input wire logic edge_mode,
  // Requests
  input wire logic ext_req,
  input wire logic periph_req,
  input wire logic consume,
  // Result
  output logic pending
);
  typedef struct packed {
    logic ext_prev;
    logic latched;
  } dmabm_det_t;
  dmabm_det_t s_q;
  dmabm_det_t s_d;

  // ***********************************************************
  // Detection
  // ***********************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ext_prev = ext_req;
    if (consume || !enable)
    begin
      s_d.latched = 1'b0;
    end
    // A new request in the consume cycle is kept
    if (source == SRC_EXT && edge_mode && ext_req && !s_q.ext_prev)
    begin
      s_d.latched = 1'b1;
    end
    if (source == SRC_PERIPH && periph_req && enable)
    begin
      s_d.latched = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Level mode follows the pin; auto needs only the enable
  always_comb
  begin
    pending = enable && (source == SRC_AUTO || s_q.latched ||
      (source == SRC_EXT && !edge_mode && ext_req));
  end

  set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && source == SRC_PERIPH && periph_req && consume) |=> pending)
    else $error("peripheral request lost on consume");
endmodule : dmabm_req_detect

// *** tb/dmabm_bus_model.sv ***
// Far-side model: system bus arbiter plus memory answering bus cycles
`timescale 1ns/1ns
module dmabm_bus_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Controller side
  input wire logic bus_req,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic slow,
  // Answers
  output logic bus_grant,
  output logic [31:0] cyc_rdata,
  output logic cyc_done
);
  logic [1:0] gcnt_q;
  logic [1:0] dcnt_q;
  logic [31:0] beat_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gcnt_q <= 2'h0;
      dcnt_q <= 2'h0;
      beat_q <= 32'h0;
      bus_grant <= 1'b0;
      cyc_rdata <= 32'h0;
      cyc_done <= 1'b0;
    end
    else
    begin
      // A slow arbiter keeps the other master on the bus for a while
      gcnt_q <= bus_req ? gcnt_q + 2'h1 : 2'h0;
      bus_grant <= bus_req && (bus_grant || !slow || gcnt_q == 2'h2);
      cyc_done <= 1'b0;
      // Read data is only valid in the answering cycle, garbage otherwise
      cyc_rdata <= ~cyc_rdata;
      if (cyc_valid && !cyc_done)
      begin
        dcnt_q <= dcnt_q + 2'h1;
        if (!slow || dcnt_q == 2'h2)
        begin
          cyc_done <= 1'b1;
          dcnt_q <= 2'h0;
          if (!cyc_write)
          begin
            cyc_rdata <= 32'h5A00_0000 + beat_q;
            beat_q <= beat_q + 32'h1;
          end
        end
      end
    end
  end
endmodule : dmabm_bus_model

// *** tb/dmabm_ctrl_test.sv ***
// Self-checking testbench of the DMA bus-mode controller
`timescale 1ns/1ns
module dmabm_ctrl_test
  import dmabm_pkg::*;
;
  // ***********************************************************
  // Signals and instances
  // ***********************************************************
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, cyc_wdata, cyc_rdata, last_rd;
  logic [NCH-1:0] ext_req, periph_req, ack;
  logic bus_req, bus_grant, cyc_valid, cyc_write, cyc_chan, cyc_done, prev_req;
  logic [1:0] cyc_size, last_sz;
  int bad_count, n_compared, n_rd, n_wr, n_ackr, n_ackw, n_rel, n_rise, n_err;
  dmabm_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_xfer_request(ext_req), .periph_request(periph_req),
    .bus_req(bus_req), .bus_grant(bus_grant), .cyc_valid(cyc_valid), .cyc_write(cyc_write),
    .cyc_chan(cyc_chan), .cyc_size(cyc_size), .cyc_wdata(cyc_wdata), .cyc_rdata(cyc_rdata),
    .cyc_done(cyc_done), .xfer_ack_strobe(ack));
  dmabm_bus_model part_u (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
    .cyc_valid(cyc_valid), .cyc_write(cyc_write), .slow(slow), .bus_grant(bus_grant),
    .cyc_rdata(cyc_rdata), .cyc_done(cyc_done));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Monitor counts cycles, strobes and bus hand-overs
  always @(posedge core_clk)
  begin
    if (prev_req && !bus_req) n_rel++;
    if (!prev_req && bus_req) n_rise++;
    prev_req = bus_req;
    if (cyc_valid && !bus_grant) n_err++;
    if (cyc_valid && cyc_done && ack[~cyc_chan]) n_err++;
    if (cyc_valid && cyc_done && cyc_write)
    begin
      n_wr++;
      n_ackw += int'(ack[cyc_chan]);
      if (cyc_wdata !== last_rd) n_err++;
    end
    else if (cyc_valid && cyc_done)
    begin
      n_rd++;
      n_ackr += int'(ack[cyc_chan]);
      last_rd = cyc_rdata;
      last_sz = cyc_size;
    end
  end
  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) bad_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  function automatic logic [31:0] mk(input logic ackw, input logic burst, input logic [1:0] sz,
      input logic edg, input logic [1:0] src, input logic sgl, input logic sp, input logic dp);
    return 32'h1 | (32'(ackw) << CTL_ACKW) | (32'(burst) << CTL_BURST) | (32'(sz) << CTL_SZ_LO)
      | (32'(edg) << CTL_EDGE) | (32'(src) << CTL_SRC) | (32'(sgl) << CTL_SINGLE)
      | (32'(sp) << CTL_SRCP) | (32'(dp) << CTL_DSTP);
  endfunction : mk
  task automatic cfg(input int ch, input logic [31:0] c, input logic [31:0] cnt);
    {n_rd, n_wr, n_ackr, n_ackw, n_rel, n_rise, n_err} = '0;
    wr(ADDR_CNT0 + ADDR_W'(ch * 8), cnt);
    wr(ADDR_CTRL0 + ADDR_W'(ch * 8), c);
  endtask : cfg
  task automatic fin(input int ch);
    logic [31:0] q;
    logic e;
    q = 32'h0;
    for (int n = 0; n < 200 && q[STA_DONE+ch] !== 1'b1; n++) apb(1'b0, ADDR_STAT, 32'h0, q, e);
    chk("done", 32'(q[STA_DONE+ch]), 32'h1);
    wr(ADDR_STAT, 32'h0000_000F);
  endtask : fin
  task automatic post(input int r, input int w, input int ar, input int aw, input int rl);
    chk("reads", 32'(n_rd), 32'(r));
    chk("writes", 32'(n_wr), 32'(w));
    if (ar >= 0) chk("ack_read", 32'(n_ackr), 32'(ar));
    chk("ack_write", 32'(n_ackw), 32'(aw));
    chk("releases", 32'(n_rel), 32'(rl));
    chk("faults", 32'(n_err), 32'h0);
  endtask : post
  task automatic wait_wr(input int k);
    for (int n = 0; n < 300 && n_wr < k; n++) @(posedge core_clk);
    if (n_wr < k) bad_count++;
  endtask : wait_wr
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic s_regs();
    logic [31:0] q;
    logic e;
    logic [ADDR_W-1:0] ad [5] = '{ADDR_CTRL0, ADDR_CNT0, ADDR_CTRL1, ADDR_CNT1, ADDR_STAT};
    foreach (ad[i])
    begin
      apb(1'b0, ad[i], 32'h0, q, e);
      chk("reset_value", q, 32'h0000_0000);
      chk("mapped", 32'(e), 32'h0);
    end
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, q, e);
    chk("unmapped_err", 32'(e), 32'h1);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk("unmapped_data", q, 32'h0);
    wr(ADDR_CTRL1, 32'h1 << CTL_BURST);
    apb(1'b0, ADDR_CTRL1, 32'h0, q, e);
    chk("mode_field", q, 32'h1 << CTL_BURST);
    wr(ADDR_CNT1, 32'hFFFF_1234);
    apb(1'b0, ADDR_CNT1, 32'h0, q, e);
    chk("count", q, 32'h0000_1234);
    wr(ADDR_CTRL1, 32'h0);
  endtask : s_regs
  task automatic s_illegal();
    logic [31:0] q;
    logic e;
    logic [31:0] bad [4] = '{mk(0, 0, SZ_BYTE, 0, SRC_PERIPH, 0, 1, 1),
      mk(0, 0, SZ_LONG, 0, SRC_AUTO, 1, 0, 0), mk(0, 0, SZ_16, 0, SRC_AUTO, 0, 0, 1),
      mk(0, 0, SZ_16, 0, SRC_PERIPH, 0, 0, 0)};
    foreach (bad[i])
    begin
      cfg(0, bad[i], 32'h1);
      repeat (4) @(posedge core_clk);
      apb(1'b0, ADDR_STAT, 32'h0, q, e);
      chk("cfg_error", q, 32'h1 << STA_ERR);
      apb(1'b0, ADDR_CTRL0, 32'h0, q, e);
      chk("enable_cleared", q, bad[i] & 32'hFFFF_FFFE);
      chk("no_bus_req", 32'(n_rise), 32'h0);
      wr(ADDR_STAT, 32'h0000_000F);
    end
  endtask : s_illegal
  task automatic s_level();
    logic [31:0] q;
    logic e;
    cfg(1, mk(0, 1, SZ_BYTE, 0, SRC_EXT, 0, 0, 0), 32'h4);
    ext_req <= 2'b10;
    wait_wr(1);
    ext_req <= 2'b00;
    repeat (30) @(posedge core_clk);
    chk("writes_before_drop", 32'(n_wr), 32'h2);
    chk("bus_released", 32'(bus_req), 32'h0);
    chk("releases", 32'(n_rel), 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0, q, e);
    chk("not_done", 32'(q[STA_DONE+1]), 32'h0);
    apb(1'b0, ADDR_CNT1, 32'h0, q, e);
    chk("units_left", q, 32'h2);
    wr(ADDR_CTRL1, 32'h0);
    // Level request in cycle-steal, word units; cfg_legal also accepts sixteen-byte units here
    cfg(1, mk(0, 0, SZ_WORD, 0, SRC_EXT, 0, 0, 0), 32'h2);
    ext_req <= 2'b10;
    fin(1);
    ext_req <= 2'b00;
    post(2, 2, 2, 0, 2);
  endtask : s_level
  initial
  begin
    {rst_n, psel, penable, pwrite, slow, prev_req} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_req = 2'h0;
    periph_req = 2'h0;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    s_regs();
    // Cycle-steal, strobe in the read cycle
    cfg(0, mk(0, 0, SZ_WORD, 0, SRC_AUTO, 0, 0, 0), 32'h2);
    fin(0);
    post(2, 2, 2, 0, 2);
    // Burst against a slow bus, strobe in the write cycle; kept short so refresh is not starved
    slow <= 1'b1;
    cfg(0, mk(1, 1, SZ_LONG, 0, SRC_AUTO, 0, 0, 0), 32'h3);
    fin(0);
    post(3, 3, 0, 3, 1);
    slow <= 1'b0;
    // Sixteen-byte units hold the bus for four long beats each
    cfg(0, mk(0, 0, SZ_16, 0, SRC_AUTO, 0, 0, 0), 32'h2);
    fin(0);
    post(8, 8, 8, 0, 2);
    chk("beat_size", 32'(last_sz), 32'(SZ_LONG));
    // Peripheral source ignores the burst setting; the first request outlasts its grant
    cfg(0, mk(0, 1, SZ_LONG, 0, SRC_PERIPH, 0, 1, 0), 32'h2);
    for (int k = 1; k <= 2; k++)
    begin
      @(posedge core_clk);
      periph_req <= 2'b01;
      repeat ((k == 1) ? 6 : 1) @(posedge core_clk);
      periph_req <= 2'b00;
      wait_wr(k);
    end
    fin(0);
    post(2, 2, 2, 0, 2);
    // Single address, edge-detected external request, burst
    cfg(0, mk(0, 1, SZ_LONG, 1, SRC_EXT, 1, 0, 0), 32'h2);
    ext_req <= 2'b01;
    fin(0);
    ext_req <= 2'b00;
    post(2, 0, 2, 0, 1);
    s_illegal();
    s_level();
    summarize();
  end
  initial
  begin
    #300000;
    bad_count++;
    summarize();
  end
endmodule : dmabm_ctrl_test
